// ---- hdl/eivm_pkg.sv ----
// shared constants and types of the external request and vector block
package eivm_pkg;
   // widths of the pin groups and vector numbers
   localparam int PC_W     = 6;
   localparam int VEC_W    = 4;
   localparam int PERIPH_N = 12;
   localparam int CNT_W    = 16;
   localparam int WB_ADR_W = 4;
   localparam int WB_DAT_W = 32;

   // program vector words
   localparam logic [VEC_W-1:0] VEC_RESET  = 4'h0;
   localparam logic [VEC_W-1:0] VEC_EXT    = 4'h1;
   localparam logic [VEC_W-1:0] VEC_PC     = 4'h2;
   localparam logic [VEC_W-1:0] VEC_PERIPH = 4'h3;
   localparam logic [VEC_W-1:0] VEC_LAST   = 4'he;

   // sense codes of the external request pin
   localparam logic [1:0] SENSE_LOW  = 2'h0;
   localparam logic [1:0] SENSE_ANY  = 2'h1;
   localparam logic [1:0] SENSE_FALL = 2'h2;
   localparam logic [1:0] SENSE_RISE = 2'h3;

   // sleep mode codes
   localparam logic [1:0] SLP_IDLE  = 2'h0;
   localparam logic [1:0] SLP_ADC   = 2'h1;
   localparam logic [1:0] SLP_PDOWN = 2'h2;

   // register byte addresses
   localparam logic [WB_ADR_W-1:0] REG_CTRL = 4'h0;
   localparam logic [WB_ADR_W-1:0] REG_MASK = 4'h4;
   localparam logic [WB_ADR_W-1:0] REG_FLAG = 4'h8;
   localparam logic [WB_ADR_W-1:0] REG_STAT = 4'hc;

   // flag register bit positions
   localparam int FLAG_EXT_BIT = 0;
   localparam int FLAG_PC_BIT  = 1;

   // mcu control register layout, bit 0 upward: sense, ext_en, pc_en, sleep_mode
   typedef struct packed {
      logic [1:0] sleep_mode;
      logic       pc_en;
      logic       ext_en;
      logic [1:0] ext_request_sense;
   } eivm_ctrl_t;
   localparam int         CTRL_W   = $bits(eivm_ctrl_t);
   localparam eivm_ctrl_t CTRL_RST = '0;
   localparam logic [PC_W-1:0] MASK_RST = '0;

   // status register layout
   typedef struct packed {
      logic [PC_W-1:0]  pc_pins;
      logic             ext_pin;
      logic             pending;
      logic [VEC_W-1:0] vector;
   } eivm_stat_t;

   // request toward the core
   typedef struct packed {
      logic             req;
      logic [VEC_W-1:0] vector;
   } eivm_core_req_t;

   // start-up fuse straps
   typedef struct packed {
      logic [1:0] startup_time_fuse;
      logic [3:0] clock_select_fuse;
   } eivm_fuse_t;

   // power state of the core
   typedef enum logic [1:0] {PS_RUN, PS_SLEEP, PS_STARTUP} eivm_pwr_t;
endpackage

// ---- hdl/eivm_sync.sv ----
// two-flop synchroniser for a group of pins
`timescale 1ns/1ps
`default_nettype none
module eivm_sync #(
   parameter int W = 1
) (
   input  wire logic         clock,
   input  wire logic         srst,
   input  wire logic         ce,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   import eivm_pkg::*;

   // both stages of the synchroniser
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } eivm_sync_st_t;

   eivm_sync_st_t st_reg;
   eivm_sync_st_t st_next;

   if (W < 1) begin : g_chk
      $error("eivm_sync width must be at least one");
   end

   // first stage feeds only the second
   always_comb begin
      st_next    = st_reg;
      st_next.s1 = din;
      st_next.s2 = st_reg.s1;
   end

   // register both stages
   always_ff @(posedge clock) begin
      if (srst) begin
         st_reg <= '0;
      end else if (ce) begin
         st_reg <= st_next;
      end
   end

   assign dout = st_reg.s2;
endmodule
`default_nettype wire

// ---- hdl/eivm_edge.sv ----
// edge and change detector for the external request pin
`timescale 1ns/1ps
`default_nettype none
module eivm_edge (
   input  wire logic       clock,
   input  wire logic       srst,
   input  wire logic       ce,
   input  wire logic       level,
   input  wire logic       sample_en,
   input  wire logic [1:0] sense,
   output logic            trig
);
   import eivm_pkg::*;

   // previous level and the registered trigger
   typedef struct packed {
      logic prev;
      logic trig;
   } eivm_edge_st_t;

   eivm_edge_st_t st_reg;
   eivm_edge_st_t st_next;

   // compare against the last sample; only while the io clock runs
   always_comb begin
      st_next      = st_reg;
      st_next.prev = level;
      st_next.trig = 1'b0;
      if (sample_en) begin
         case (sense)
            SENSE_ANY:  st_next.trig = level ^ st_reg.prev;
            SENSE_FALL: st_next.trig = st_reg.prev & ~level;
            SENSE_RISE: st_next.trig = ~st_reg.prev & level;
            default:    st_next.trig = 1'b0;
         endcase
      end
   end

   // register the detector; reset takes the idle high level
   always_ff @(posedge clock) begin
      if (srst) begin
         st_reg <= '{prev: 1'b1, trig: 1'b0};
      end else if (ce) begin
         st_reg <= st_next;
      end
   end

   assign trig = st_reg.trig;
endmodule
`default_nettype wire

// ---- hdl/eivm_top.sv ----
// external request detection, vector selection and sleep wake-up
// How it works
// - reset makes the core fetch word zero
// - fixed one-word vectors one to fourteen
// - nothing enabled means no vector branch
// - pins trigger even when driven as outputs
// - masked pin toggle raises pin-change request
// - pin-change detection works with io clock stopped
// - sense bits choose falling, rising or low
// - low level requests continuously while held
// - edges need the io clock running
// - low level detected with io clock stopped
// - io clock stopped in all but idle
// - level must outlast start-up or no interrupt
// - vanished level resumes after the sleep
// - start-up length comes from fuse straps
// - sense codes: low, change, fall, rise
// - pulses over one clock are caught
// - flag set by edge, cleared by entry
// - mask bits need the global pin-change enable
`timescale 1ns/1ps
`default_nettype none
module eivm_top #(
   parameter int STARTUP_BASE = 1024
) (
   input  wire logic                          clock,
   input  wire logic                          srst,
   input  wire logic                          ce,
   input  wire logic                          wb_cyc_i,
   input  wire logic                          wb_stb_i,
   input  wire logic                          wb_we_i,
   input  wire logic [eivm_pkg::WB_ADR_W-1:0] wb_adr_i,
   input  wire logic [3:0]                    wb_sel_i,
   input  wire logic [eivm_pkg::WB_DAT_W-1:0] wb_dat_i,
   output logic      [eivm_pkg::WB_DAT_W-1:0] wb_dat_o,
   output logic                               wb_ack_o,
   input  wire logic                          ext_request_pin,
   input  wire logic [eivm_pkg::PC_W-1:0]     pin_change_inputs,
   input  wire logic [eivm_pkg::PERIPH_N-1:0] periph_req,
   input  wire eivm_pkg::eivm_fuse_t          fuse,
   input  wire logic                          global_irq_en,
   input  wire logic                          sleep_cmd,
   input  wire logic                          core_ack,
   output eivm_pkg::eivm_core_req_t           core_req,
   output logic                               reset_fetch,
   output logic                               io_clk_run,
   output logic                               cpu_halt,
   output logic                               wake_resume
);
   import eivm_pkg::*;

   localparam int NVEC = 16;

   // whole state of the block
   typedef struct packed {
      eivm_ctrl_t          mcu_control_reg;
      logic [PC_W-1:0]     pin_change_mask;
      logic                ext_request_flag;
      logic                pc_flag;
      logic [PC_W-1:0]     pc_prev;
      eivm_pwr_t           pwr;
      logic [1:0]          slp_mode;
      logic [CNT_W-1:0]    cnt;
      eivm_core_req_t      creq;
      logic                rst_fetch;
      logic                io_run;
      logic                halt;
      logic                resume;
      logic                ack;
      logic [WB_DAT_W-1:0] rdata;
   } eivm_state_t;

   eivm_state_t st_reg;
   eivm_state_t st_next;

   // synchronised pins and the edge trigger
   logic            ext_lvl;
   logic [PC_W-1:0] pc_lvl;
   logic            ext_trig;

   // decoded request terms
   logic [NVEC-1:0] pend;
   logic [PC_W-1:0] pc_hit;
   logic            level_mode;
   logic            any_pend;
   logic            take_irq;
   logic            async_wake;
   logic            wake;
   logic            wb_acc;
   logic            wr_lo;
   eivm_stat_t      stat;
   logic [VEC_W-1:0] best_vec;

   // parameters the counter cannot hold are refused
   if (STARTUP_BASE < 1 || STARTUP_BASE > 8190) begin : g_chk
      $error("STARTUP_BASE out of range for the start-up counter");
   end

   // lowest numbered pending vector, zero when none
   function automatic logic [VEC_W-1:0] lowest_vec(input logic [NVEC-1:0] p);
      logic [VEC_W-1:0] v;
      v = VEC_RESET;
      for (int i = NVEC - 1; i > 0; i--) begin
         if (p[i]) begin
            v = VEC_W'(i);
         end
      end
      return v;
   endfunction

   // start-up length in clock cycles minus one
   function automatic logic [CNT_W-1:0] startup_cycles(input eivm_fuse_t f);
      logic [31:0] c;
      c = (32'(STARTUP_BASE) << f.startup_time_fuse) + 32'(f.clock_select_fuse);
      return CNT_W'(c - 32'h1);
   endfunction

   eivm_sync #(
      .W (1)
   ) u_sync_ext (
      .clock (clock),
      .srst  (srst),
      .ce    (ce),
      .din   (ext_request_pin),
      .dout  (ext_lvl)
   );

   // pin-change inputs take the same two stages
   eivm_sync #(
      .W (PC_W)
   ) u_sync_pc (
      .clock (clock),
      .srst  (srst),
      .ce    (ce),
      .din   (pin_change_inputs),
      .dout  (pc_lvl)
   );

   eivm_edge u_edge (
      .clock     (clock),
      .srst      (srst),
      .ce        (ce),
      .level     (ext_lvl),
      .sample_en (st_reg.io_run),
      .sense     (st_reg.mcu_control_reg.ext_request_sense),
      .trig      (ext_trig)
   );

   // request decode, priority and wake terms
   always_comb begin
      level_mode = (st_reg.mcu_control_reg.ext_request_sense == SENSE_LOW);
      pc_hit = (pc_lvl ^ st_reg.pc_prev) & st_reg.pin_change_mask;
      pend = '0;
      if (st_reg.mcu_control_reg.ext_en) begin
         pend[VEC_EXT] = level_mode ? ~ext_lvl : st_reg.ext_request_flag;
      end
      pend[VEC_PC] = st_reg.mcu_control_reg.pc_en & st_reg.pc_flag;
      for (int i = 0; i < PERIPH_N; i++) begin
         pend[int'(VEC_PERIPH) + i] = periph_req[i];
      end
      best_vec = lowest_vec(pend);
      any_pend = |pend;
      // no request without an enabled source
      take_irq = global_irq_en & any_pend;
      async_wake = (st_reg.mcu_control_reg.ext_en & level_mode & ~ext_lvl)
                 | (st_reg.mcu_control_reg.pc_en & ((|pc_hit) | st_reg.pc_flag))
                 | (|periph_req);
      // idle keeps the io clock, so any pending source wakes
      wake = (st_reg.slp_mode == SLP_IDLE) ? (any_pend | async_wake) : async_wake;
      // bus access; a low-byte write lands at the edge that sees ack high
      wb_acc = wb_cyc_i & wb_stb_i & ~st_reg.ack;
      wr_lo  = wb_cyc_i & wb_stb_i & st_reg.ack & wb_we_i & wb_sel_i[0];
      // status word
      stat.pc_pins = pc_lvl;
      stat.ext_pin = ext_lvl;
      stat.pending = any_pend;
      stat.vector  = best_vec;
   end

   // next-state logic
   always_comb begin
      st_next        = st_reg;
      st_next.ack    = wb_acc;
      st_next.resume = 1'b0;

      st_next.pc_prev = pc_lvl;

      // flag cleared on entry or write one
      if (core_ack && st_reg.creq.req && st_reg.creq.vector == VEC_EXT) begin
         st_next.ext_request_flag = 1'b0;
      end
      if (wr_lo && wb_adr_i == REG_FLAG && wb_dat_i[FLAG_EXT_BIT]) begin
         st_next.ext_request_flag = 1'b0;
      end
      // any seen edge sets, set wins
      if (ext_trig) begin
         st_next.ext_request_flag = 1'b1;
      end
      if (level_mode) begin
         st_next.ext_request_flag = 1'b0;
      end

      // pin-change flag: entry or write one clears
      if (core_ack && st_reg.creq.req && st_reg.creq.vector == VEC_PC) begin
         st_next.pc_flag = 1'b0;
      end
      if (wr_lo && wb_adr_i == REG_FLAG && wb_dat_i[FLAG_PC_BIT]) begin
         st_next.pc_flag = 1'b0;
      end
      // a masked toggle sets, set wins
      if (|pc_hit) begin
         st_next.pc_flag = 1'b1;
      end

      // control and mask writes, low byte only
      if (wr_lo && wb_adr_i == REG_CTRL) begin
         st_next.mcu_control_reg = wb_dat_i[CTRL_W-1:0];
      end
      if (wr_lo && wb_adr_i == REG_MASK) begin
         st_next.pin_change_mask = wb_dat_i[PC_W-1:0];
      end

      // read data, unmapped reads zero
      st_next.rdata = '0;
      if (wb_acc && !wb_we_i) begin
         case (wb_adr_i)
            REG_CTRL: st_next.rdata = WB_DAT_W'(st_reg.mcu_control_reg);
            REG_MASK: st_next.rdata = WB_DAT_W'(st_reg.pin_change_mask);
            REG_FLAG: begin
               st_next.rdata[FLAG_EXT_BIT] = st_reg.ext_request_flag;
               st_next.rdata[FLAG_PC_BIT]  = st_reg.pc_flag;
            end
            REG_STAT: st_next.rdata = WB_DAT_W'(stat);
            default:  st_next.rdata = '0;
         endcase
      end

      if (st_reg.rst_fetch && core_ack) begin
         st_next.rst_fetch = 1'b0;
      end

      // power state machine
      case (st_reg.pwr)
         PS_RUN: begin
            st_next.halt   = 1'b0;
            st_next.io_run = 1'b1;
            if (sleep_cmd && !st_reg.rst_fetch) begin
               st_next.pwr      = PS_SLEEP;
               st_next.slp_mode = st_reg.mcu_control_reg.sleep_mode;
               st_next.halt     = 1'b1;
               st_next.io_run   = (st_reg.mcu_control_reg.sleep_mode == SLP_IDLE);
            end
         end
         PS_SLEEP: begin
            if (wake) begin
               if (st_reg.slp_mode == SLP_PDOWN) begin
                  st_next.pwr = PS_STARTUP;
                  st_next.cnt = startup_cycles(fuse);
               end else begin
                  st_next.pwr    = PS_RUN;
                  st_next.halt   = 1'b0;
                  st_next.io_run = 1'b1;
                  // a pin change seen this edge sets its flag now, so it counts as taken
                  st_next.resume = ~(take_irq | (global_irq_en & st_reg.mcu_control_reg.pc_en & (|pc_hit)));
               end
            end
         end
         PS_STARTUP: begin
            if (st_reg.cnt == '0) begin
               st_next.pwr    = PS_RUN;
               st_next.halt   = 1'b0;
               st_next.io_run = 1'b1;
               st_next.resume = ~take_irq;
            end else begin
               st_next.cnt = st_reg.cnt - CNT_W'(1);
            end
         end
         default: begin
            st_next.pwr    = PS_RUN;
            st_next.halt   = 1'b0;
            st_next.io_run = 1'b1;
         end
      endcase

      // request toward the core
      if (st_next.rst_fetch) begin
         st_next.creq.req    = 1'b1;
         st_next.creq.vector = VEC_RESET;
      end else if (st_reg.pwr == PS_RUN && st_next.pwr == PS_RUN) begin
         st_next.creq.req    = take_irq;
         st_next.creq.vector = take_irq ? best_vec : VEC_RESET;
      end else begin
         st_next.creq.req    = 1'b0;
         st_next.creq.vector = VEC_RESET;
      end
      // a taken request, the reset fetch too, drops for one cycle so it is not taken twice
      if (core_ack && st_reg.creq.req) begin
         st_next.creq.req = 1'b0;
      end
   end

   // register the whole state
   always_ff @(posedge clock) begin
      if (srst) begin
         st_reg                  <= '0;
         st_reg.mcu_control_reg  <= CTRL_RST;
         st_reg.pin_change_mask  <= MASK_RST;
         st_reg.pwr              <= PS_RUN;
         st_reg.creq.req         <= 1'b1;
         st_reg.creq.vector      <= VEC_RESET;
         st_reg.rst_fetch        <= 1'b1;
         st_reg.io_run           <= 1'b1;
      end else if (ce) begin
         st_reg <= st_next;
      end
   end

   // outputs straight from the state
   assign wb_dat_o    = st_reg.rdata;
   assign wb_ack_o    = st_reg.ack;
   assign core_req    = st_reg.creq;
   assign reset_fetch = st_reg.rst_fetch;
   assign io_clk_run  = st_reg.io_run;
   assign cpu_halt    = st_reg.halt;
   assign wake_resume = st_reg.resume;
endmodule
`default_nettype wire

// ---- tb/eivm_top_assertions.sv ----
// concurrent checks on the ports of the external request and vector block
`timescale 1ns/1ps
`default_nettype none
module eivm_chk (
   input wire logic                     clock,
   input wire logic                     srst,
   input wire logic                     ce,
   input wire logic                     global_irq_en,
   input wire logic                     sleep_cmd,
   input wire logic                     core_ack,
   input wire eivm_pkg::eivm_core_req_t core_req,
   input wire logic                     reset_fetch,
   input wire logic                     io_clk_run,
   input wire logic                     cpu_halt,
   input wire logic                     wake_resume
);
   import eivm_pkg::*;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (srst);

   reset_fetch_a: assert property ($fell(srst) |->
      reset_fetch && core_req.req && core_req.vector == VEC_RESET) else $error("no word zero fetch after reset");
   vector_range_a: assert property (core_req.req |-> core_req.vector <= VEC_LAST)
      else $error("vector beyond the table");
   reset_word_a: assert property (core_req.req && !reset_fetch |-> core_req.vector != VEC_RESET)
      else $error("interrupt shown at the reset word");
   no_enable_a: assert property (!global_irq_en && !reset_fetch |=> !core_req.req)
      else $error("request while interrupts disabled");
   entry_drop_a: assert property (core_ack && core_req.req |=> !core_req.req)
      else $error("request kept after entry");
   halt_quiet_a: assert property (cpu_halt |-> !core_req.req)
      else $error("request while halted");
   run_clock_a: assert property (!cpu_halt |-> io_clk_run)
      else $error("io clock off while running");
   sleep_halt_a: assert property (sleep_cmd && ce && !cpu_halt && !reset_fetch |=> cpu_halt)
      else $error("sleep command did not halt");
   resume_pulse_a: assert property (wake_resume |-> !cpu_halt ##1 !wake_resume)
      else $error("resume pulse malformed");

   entry_cov: cover property (core_ack && core_req.req);
   resume_cov: cover property (wake_resume);
   sleep_cov: cover property ($rose(cpu_halt));
endmodule

bind eivm_top eivm_chk i_chk (.clock, .srst, .ce, .global_irq_en, .sleep_cmd, .core_ack, .core_req,
   .reset_fetch, .io_clk_run, .cpu_halt, .wake_resume);
`default_nettype wire

// ---- tb/eivm_core_model.sv ----
// model of the core interrupt entry: takes a shown request after a delay
`timescale 1ns/1ps
`default_nettype none
module eivm_core_model (
   input  wire logic                     clock,
   input  wire logic                     accept,
   input  wire logic [3:0]               dly,
   input  wire eivm_pkg::eivm_core_req_t core_req,
   output logic                          core_ack
);
   import eivm_pkg::*;
   logic [3:0] wait_cnt; // edges the request has been seen

   initial begin
      core_ack = 1'b0;
      wait_cnt = 4'h0;
   end

   // one-cycle entry pulse once the request has stood dly edges
   always @(posedge clock) begin
      core_ack <= 1'b0;
      if (core_req.req && accept && !core_ack) begin
         if (wait_cnt >= dly) begin
            core_ack <= 1'b1;
            wait_cnt <= 4'h0;
         end else begin
            wait_cnt <= wait_cnt + 4'h1;
         end
      end else begin
         wait_cnt <= 4'h0;
      end
   end
endmodule
`default_nettype wire

// ---- tb/eivm_top_tb.sv ----
// self-checking bench of the external request and vector block
`timescale 1ns/1ps
`default_nettype none
module eivm_top_tb;
   import eivm_pkg::*;
   logic           clock = 1'b0;
   logic           srst = 1'b1;
   logic           ce = 1'b1;
   logic           cyc = 1'b0;    // cycle and strobe together
   logic           we = 1'b0;
   logic [3:0]     adr = 4'h0;
   logic [31:0]    wdat = 32'h0;
   logic [31:0]    rdat;
   logic           ack;
   logic           ext_pin = 1'b1;
   logic [5:0]     pc_pins = 6'h0;
   logic [11:0]    periph = 12'h0;
   eivm_fuse_t     fuse = '0;
   logic           gie = 1'b0;
   logic           slp = 1'b0;
   logic           accept = 1'b0; // core takes entries
   logic [3:0]     dly = 4'h0;    // core answer delay
   logic           core_ack;
   eivm_core_req_t core_req;
   logic           reset_fetch;
   logic           io_clk_run;
   logic           cpu_halt;
   logic           wake_resume;
   logic [15:0]    lfsr = 16'hb4ff;
   int             mismatches = 0;
   int             n_compared = 0;
   int             n_wake = 0;    // resume pulses awaited
   logic [3:0]     exp_vec[$];    // vectors to be taken
   logic [31:0]    exp_rd[$];     // read data awaited

   always #50 clock = ~clock;

   eivm_top #(.STARTUP_BASE(4)) i_dut (
      .clock(clock), .srst(srst), .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .ext_request_pin(ext_pin), .pin_change_inputs(pc_pins), .periph_req(periph), .fuse(fuse),
      .global_irq_en(gie), .sleep_cmd(slp), .core_ack(core_ack), .core_req(core_req),
      .reset_fetch(reset_fetch), .io_clk_run(io_clk_run), .cpu_halt(cpu_halt), .wake_resume(wake_resume));

   eivm_core_model i_core (.clock(clock), .accept(accept), .dly(dly), .core_req(core_req), .core_ack(core_ack));

   function automatic logic [15:0] next_rand(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction

   task automatic report_and_stop;
      if (mismatches == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic give_up;
      mismatches++;
      report_and_stop();
   endtask

   // single bus access, held until the acknowledge edge
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clock);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge clock);
         n++;
      end while (ack !== 1'b1 && n < 50);
      if (ack !== 1'b1) give_up();
      cyc <= 1'b0;
      we <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      exp_rd.push_back(e);
      wb(1'b0, a, 32'h0);
   endtask

   task automatic toggle(input int k);
      @(posedge clock);
      pc_pins[k] <= ~pc_pins[k];
   endtask

   task automatic sleep_now;
      @(posedge clock);
      slp <= 1'b1;
      @(posedge clock);
      slp <= 1'b0;
   endtask

   // wait until every note has been matched
   task automatic settle;
      int n;
      n = 0;
      do begin
         @(posedge clock);
         #1;
         n++;
      end while (exp_vec.size() + exp_rd.size() + n_wake != 0 && n < 300);
      if (exp_vec.size() + exp_rd.size() + n_wake != 0) give_up();
   endtask

   // core stops taking, sources drop, flags cleared, then reopen
   task automatic calm;
      settle();
      @(posedge clock);
      accept <= 1'b0;
      gie <= 1'b0;
      ext_pin <= 1'b1;
      periph <= 12'h0;
      repeat (6) @(posedge clock);
      wb(1'b1, REG_FLAG, 32'h3);
      accept <= 1'b1;
      gie <= 1'b1;
   endtask

   // watcher: each entry and read answer meets the oldest note
   always @(posedge clock) begin
      if (!srst && core_ack && core_req.req) begin
         if (exp_vec.size() == 0) begin
            chk("unasked entry", 32'hffffffff, 32'(core_req.vector));
         end else begin
            chk("vector", 32'(exp_vec.pop_front()), 32'(core_req.vector));
         end
      end
      if (ack && cyc && !we && exp_rd.size() != 0) begin
         chk("read data", exp_rd.pop_front(), rdat);
      end
      if (wake_resume) begin
         chk("resume pulse awaited", 32'(n_wake > 0), 32'h1);
         if (n_wake > 0) n_wake--;
      end
   end

   initial begin
      int k;
      int r;
      exp_vec.push_back(VEC_RESET);
      repeat (10) @(posedge clock);
      lfsr = next_rand(lfsr);
      r = lfsr % 12;
      srst <= 1'b0;
      accept <= 1'b1;
      fuse <= {1'b1, lfsr[4:0]};
      settle();
      // cleared registers, unmapped word reads zero
      rd(REG_CTRL, 32'h0);
      // frozen block answers only once the enable returns
      ce <= 1'b0;
      fork
         rd(REG_MASK, 32'h0);
         begin
            repeat (5) @(posedge clock);
            ce <= 1'b1;
         end
      join
      wb(1'b1, 4'h2, 32'hff);
      rd(4'h2, 32'h0);
      wb(1'b1, REG_FLAG, 32'h3);
      gie <= 1'b1;
      for (k = 0; k < 4; k++) begin
         @(posedge clock);
         ext_pin <= ~ext_pin;
         pc_pins <= ~pc_pins;
         repeat (8) @(posedge clock);
      end
      // masked pin waits for the group enable
      k = r % 6;
      wb(1'b1, REG_MASK, 32'(1 << k));
      toggle(k);
      repeat (8) @(posedge clock);
      rd(REG_FLAG, 32'h2);
      exp_vec.push_back(VEC_PC);
      wb(1'b1, REG_CTRL, 32'h8);
      settle();
      // each pin alone, an unmasked neighbour quiet
      for (k = 0; k < 6; k++) begin
         wb(1'b1, REG_MASK, 32'(1 << k));
         toggle((k + 1) % 6);
         repeat (8) @(posedge clock);
         toggle(k);
         exp_vec.push_back(VEC_PC);
         settle();
      end
      for (k = 1; k < 4; k++) begin
         wb(1'b1, REG_CTRL, 32'(4 | k));
         wb(1'b1, REG_FLAG, 32'h1);
         @(posedge clock);
         ext_pin <= 1'b0;
         if (k != 3) exp_vec.push_back(VEC_EXT);
         repeat (k == 1 ? 12 : 2) @(posedge clock);
         ext_pin <= 1'b1;
         if (k != 2) exp_vec.push_back(VEC_EXT);
         settle();
      end
      // held low level keeps asking, flag stays clear
      wb(1'b1, REG_CTRL, 32'h4);
      @(posedge clock);
      ext_pin <= 1'b0;
      repeat (3) exp_vec.push_back(VEC_EXT);
      rd(REG_FLAG, 32'h0);
      calm();
      // every peripheral vector, one beside a pin change
      wb(1'b1, REG_CTRL, 32'h8);
      wb(1'b1, REG_MASK, 32'h1);
      for (k = 0; k < 12; k++) begin
         @(posedge clock);
         gie <= 1'b0;
         dly <= 4'(k % 4);
         periph <= 12'(1 << k);
         pc_pins[0] <= pc_pins[0] ^ (k == r);
         repeat (8) @(posedge clock);
         if (k == r) exp_vec.push_back(VEC_PC);
         exp_vec.push_back(VEC_PERIPH + 4'(k));
         gie <= 1'b1;
         calm();
      end
      // pin change wakes idle and power-down
      for (k = 0; k < 2; k++) begin
         wb(1'b1, REG_CTRL, 32'(8 | (k << 5)));
         sleep_now();
         repeat (3) @(posedge clock);
         chk("io clock run", 32'(k == 0), 32'(io_clk_run));
         toggle(0);
         exp_vec.push_back(VEC_PC);
         calm();
      end
      // low level wakes power-down; a short one gives no entry
      wb(1'b1, REG_CTRL, 32'h24);
      for (k = 0; k < 2; k++) begin
         sleep_now();
         ext_pin <= 1'b0;
         if (k == 0) begin
            n_wake++;
            repeat (3) @(posedge clock);
            ext_pin <= 1'b1;
         end else begin
            exp_vec.push_back(VEC_EXT);
         end
         calm();
      end
      settle();
      report_and_stop();
   end
endmodule
`default_nettype wire
